/* logic/acs_pkg.sv */
`default_nettype none
package acs_pkg;
	// ************************************************
	// register byte offsets
	// ************************************************
	localparam logic [7:0] OFF_CTRL_A   = 8'h00; // converter_control_a
	localparam logic [7:0] OFF_CTRL_B   = 8'h04; // converter_control_b
	localparam logic [7:0] OFF_RES_HIGH = 8'h08; // result_high
	localparam logic [7:0] OFF_RES_LOW  = 8'h0c; // result_low
	localparam logic [7:0] OFF_FLAGS    = 8'h10; // peripheral_flags_1
	localparam logic [7:0] OFF_ENABLES  = 8'h14; // peripheral_enables_1
	localparam logic [7:0] OFF_IRQ_CTRL = 8'h18; // irq_control

	// ************************************************
	// field positions
	// ************************************************
	localparam int BIT_ON       = 0; // converter_on
	localparam int BIT_GO       = 1; // go/done
	localparam int POS_CHAN     = 2; // channel_select lsb
	localparam int POS_CLKSEL   = 4; // conv_clock_select lsb
	localparam int BIT_REFSEL   = 0; // reference_select
	localparam int BIT_DONE     = 0; // conversion_done_flag
	localparam int BIT_IRQ_EN   = 0; // conversion_irq_enable
	localparam int BIT_PERI_EN  = 6; // peripheral_irq_enable
	localparam int BIT_GLOB_EN  = 7; // global_irq_enable

	// ************************************************
	// reset values and conversion figures
	// ************************************************
	localparam logic [4:0] CHAN_RESET   = 5'h00;
	localparam logic [2:0] CLKSEL_RESET = 3'h0;
	localparam logic [9:0] RESULT_RESET = 10'h000;
	localparam logic [9:0] SAR_FIRST    = 10'h200; // msb trial
	localparam logic [3:0] CONV_PERIODS = 4'hb;    // bit periods per conversion
	localparam logic [1:0] ABORT_TICKS  = 2'h2;    // holdoff after abort
	localparam logic [6:0] DIV_8        = 7'h08;
	localparam logic [6:0] DIV_16       = 7'h10;
	localparam logic [6:0] DIV_32       = 7'h20;
	localparam logic [6:0] DIV_64       = 7'h40;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_HOLDOFF} acs_state_t;
endpackage
`default_nettype wire

/* logic/acs_sequencer.sv */
// What this block does
// RL1: ten-bit SAR result, right justified only
// RL2: five-bit channel field drives the mux
// RL3: software waits after changing the channel
// RL4: clock code picks osc divisor or RC
// RL5: eleven bit periods per conversion
// RL6: software avoids osc/8 at 8 MHz
// RL7: done flag set on every completion
// RL8: done flag cleared only by software
// RL9: irq request when flag and enable set
// RL10: irq wakes from sleep, core vectors if enabled
// RL11: runs only when on; go starts conversion
// RL12: software enables first, starts later
// RL13: completion clears go, sets flag, loads result
// RL14: clearing go aborts, result kept
// RL15: two bit periods holdoff, then reacquire
// RL16: reset turns off and cancels conversion
// RL17: no conversion progress while asleep
// RL18: software sets pin input and analog
// RL19: software waits acquisition, then polls or interrupts
// RL20: channel codes map, reserved codes unused
// RL21: go reads one while converting
// RL22: high result holds bits nine and eight
// RL23: one reference select bit, reserved clock codes
// RL24: go with converter off is ignored
// RL25: start during conversion is ignored
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer #(
	parameter bit         LARGE_VARIANT = 1'b1,  // three extra pin channels
	parameter logic [6:0] RC_DIV        = 7'h10  // rc clock divisor
) (
	input  wire logic        ref_clk,       // 100 MHz clock
	input  wire logic        arst_n,        // async reset
	input  wire logic [7:0]  s_axi_awaddr,  // write address
	input  wire logic        s_axi_awvalid, // write address valid
	output logic             s_axi_awready, // write address ready
	input  wire logic [31:0] s_axi_wdata,   // write data
	input  wire logic [3:0]  s_axi_wstrb,   // write strobes
	input  wire logic        s_axi_wvalid,  // write data valid
	output logic             s_axi_wready,  // write data ready
	output logic [1:0]       s_axi_bresp,   // write response
	output logic             s_axi_bvalid,  // write response valid
	input  wire logic        s_axi_bready,  // write response ready
	input  wire logic [7:0]  s_axi_araddr,  // read address
	input  wire logic        s_axi_arvalid, // read address valid
	output logic             s_axi_arready, // read address ready
	output logic [31:0]      s_axi_rdata,   // read data
	output logic [1:0]       s_axi_rresp,   // read response
	output logic             s_axi_rvalid,  // read data valid
	input  wire logic        s_axi_rready,  // read data ready
	input  wire logic        sleep_mode,    // device asleep
	input  wire logic        cmp_in,        // comparator: input at or above trial
	output logic [4:0]       mux_channel,   // analog mux select
	output logic             conv_enable,   // converter powered
	output logic             ref_select,    // reference select
	output logic             sample_track,  // sample-and-hold tracking
	output logic [9:0]       sar_code,      // trial code to converter
	output logic             conv_irq,      // converter irq request
	output logic             core_irq,      // irq delivered to core
	output logic             wake_req       // wake from sleep
);
	// ************************************************
	// register storage and state
	// ************************************************
	acs_pkg::acs_state_t state_reg;
	logic       on_reg;
	logic [4:0] chan_reg;
	logic [2:0] clksel_reg;
	logic       refsel_reg;
	logic [9:0] result_reg;
	logic       flag_reg;
	logic       irq_en_reg;
	logic       peri_en_reg;
	logic       glob_en_reg;
	logic [3:0] period_reg;
	logic [1:0] hold_reg;
	logic [1:0] sync1_reg;
	logic [1:0] sync2_reg;
	logic       tick;

	// ************************************************
	// bus slave
	// ************************************************
	logic [7:0]  awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        aw_full_reg;
	logic        w_full_reg;
	logic        wr_fire;
	logic        wr_lane0;

	// true when the word address matches a register offset
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		return addr[7:2] == off[7:2];
	endfunction

	function automatic logic mapped(input logic [7:0] addr);
		return hit(addr, acs_pkg::OFF_CTRL_A) || hit(addr, acs_pkg::OFF_CTRL_B)
			|| hit(addr, acs_pkg::OFF_RES_HIGH) || hit(addr, acs_pkg::OFF_RES_LOW)
			|| hit(addr, acs_pkg::OFF_FLAGS) || hit(addr, acs_pkg::OFF_ENABLES)
			|| hit(addr, acs_pkg::OFF_IRQ_CTRL);
	endfunction

	assign wr_fire  = aw_full_reg && w_full_reg && !s_axi_bvalid;
	assign wr_lane0 = wr_fire && wstrb_reg[0];

	// address and data latch in either order
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_full_reg   <= 1'b0;
			w_full_reg    <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			awaddr_reg    <= 8'h00;
			wdata_reg     <= 32'h0000_0000;
			wstrb_reg     <= 4'h0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			aw_full_reg   <= 1'b0;
			w_full_reg    <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg   <= 1'b1;
				s_axi_awready <= 1'b0;
				awaddr_reg    <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg   <= 1'b1;
				s_axi_wready <= 1'b0;
				wdata_reg    <= s_axi_wdata;
				wstrb_reg    <= s_axi_wstrb;
			end
		end
	end

	// write response one cycle after both halves are held
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= acs_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= mapped(awaddr_reg) ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read data captured at the address handshake
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= acs_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= mapped(s_axi_araddr) ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
			s_axi_rdata   <= 32'h0000_0000;
			if (hit(s_axi_araddr, acs_pkg::OFF_CTRL_A)) begin
				s_axi_rdata[acs_pkg::POS_CHAN +: 5] <= chan_reg;
				s_axi_rdata[acs_pkg::BIT_GO]        <= state_reg == acs_pkg::ST_CONV; // [RL21]
				s_axi_rdata[acs_pkg::BIT_ON]        <= on_reg;
			end
			if (hit(s_axi_araddr, acs_pkg::OFF_CTRL_B)) begin
				s_axi_rdata[acs_pkg::POS_CLKSEL +: 3] <= clksel_reg;
				s_axi_rdata[acs_pkg::BIT_REFSEL]      <= refsel_reg;
			end
			if (hit(s_axi_araddr, acs_pkg::OFF_RES_HIGH)) begin
				s_axi_rdata[1:0] <= result_reg[9:8]; // [RL22]
			end
			if (hit(s_axi_araddr, acs_pkg::OFF_RES_LOW)) begin
				s_axi_rdata[7:0] <= result_reg[7:0]; // [RL22]
			end
			if (hit(s_axi_araddr, acs_pkg::OFF_FLAGS)) begin
				s_axi_rdata[acs_pkg::BIT_DONE] <= flag_reg;
			end
			if (hit(s_axi_araddr, acs_pkg::OFF_ENABLES)) begin
				s_axi_rdata[acs_pkg::BIT_IRQ_EN] <= irq_en_reg;
			end
			if (hit(s_axi_araddr, acs_pkg::OFF_IRQ_CTRL)) begin
				s_axi_rdata[acs_pkg::BIT_PERI_EN] <= peri_en_reg;
				s_axi_rdata[acs_pkg::BIT_GLOB_EN] <= glob_en_reg;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ************************************************
	// pin synchronisers: comparator and sleep
	// ************************************************
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= 2'h0;
			sync2_reg <= 2'h0;
		end else begin
			sync1_reg <= {sleep_mode, cmp_in};
			sync2_reg <= sync1_reg;
		end
	end

	logic cmp_s;
	logic sleep_s;
	assign cmp_s   = sync2_reg[0];
	assign sleep_s = sync2_reg[1];

	// ************************************************
	// control decode
	// ************************************************
	logic wr_ctla;
	logic start_ok;
	logic abort;
	logic finish;
	logic [3:0] bit_idx;
	logic [9:0] decided;

	assign wr_ctla  = wr_lane0 && hit(awaddr_reg, acs_pkg::OFF_CTRL_A);
	// start needs the converter already on and the sequencer idle
	assign start_ok = wr_ctla && wdata_reg[acs_pkg::BIT_GO] && on_reg // [RL11] [RL12] [RL24]
		&& wdata_reg[acs_pkg::BIT_ON] && state_reg == acs_pkg::ST_IDLE // [RL25]
		&& !sleep_s; // [RL17]
	// clearing go or switching off mid-conversion
	assign abort    = state_reg == acs_pkg::ST_CONV && wr_ctla
		&& !(wdata_reg[acs_pkg::BIT_GO] && wdata_reg[acs_pkg::BIT_ON]); // [RL14]
	assign finish   = state_reg == acs_pkg::ST_CONV && tick && !abort
		&& period_reg == acs_pkg::CONV_PERIODS - 4'h1; // [RL5]
	assign bit_idx  = 4'ha - period_reg;

	// trial with the current bit decided by the comparator
	always_comb begin
		decided = sar_code;
		if (period_reg != 4'h0 && !cmp_s) begin
			decided[bit_idx] = 1'b0; // [RL1]
		end
	end

	// bit period enable; counter cleared while asleep and restarted on abort so holdoff is whole periods
	acs_tick_gen #(.RC_DIV(RC_DIV)) u_tick (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.run     (on_reg && state_reg != acs_pkg::ST_IDLE && !sleep_s && !abort), // [RL15] [RL17]
		.clk_sel (clksel_reg), // [RL4]
		.tick    (tick)
	);

	// ************************************************
	// configuration registers
	// ************************************************
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			on_reg      <= 1'b0; // [RL16]
			chan_reg    <= acs_pkg::CHAN_RESET;
			clksel_reg  <= acs_pkg::CLKSEL_RESET; // [RL23]
			refsel_reg  <= 1'b0;
			irq_en_reg  <= 1'b0;
			peri_en_reg <= 1'b0;
			glob_en_reg <= 1'b0;
		end else begin
			if (wr_ctla) begin
				on_reg   <= wdata_reg[acs_pkg::BIT_ON];
				chan_reg <= wdata_reg[acs_pkg::POS_CHAN +: 5]; // [RL2]
			end
			if (wr_lane0 && hit(awaddr_reg, acs_pkg::OFF_CTRL_B)) begin
				clksel_reg <= wdata_reg[acs_pkg::POS_CLKSEL +: 3];
				refsel_reg <= wdata_reg[acs_pkg::BIT_REFSEL]; // [RL23]
			end
			if (wr_lane0 && hit(awaddr_reg, acs_pkg::OFF_ENABLES)) begin
				irq_en_reg <= wdata_reg[acs_pkg::BIT_IRQ_EN];
			end
			if (wr_lane0 && hit(awaddr_reg, acs_pkg::OFF_IRQ_CTRL)) begin
				peri_en_reg <= wdata_reg[acs_pkg::BIT_PERI_EN];
				glob_en_reg <= wdata_reg[acs_pkg::BIT_GLOB_EN];
			end
		end
	end

	// ************************************************
	// conversion sequencer
	// ************************************************
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg  <= acs_pkg::ST_IDLE; // [RL16]
			period_reg <= 4'h0;
			hold_reg   <= 2'h0;
			sar_code   <= acs_pkg::SAR_FIRST;
			result_reg <= acs_pkg::RESULT_RESET;
		end else if (wr_ctla && !wdata_reg[acs_pkg::BIT_ON]) begin
			state_reg <= acs_pkg::ST_IDLE; // [RL11]
		end else begin
			unique case (state_reg)
				acs_pkg::ST_IDLE: begin
					if (start_ok) begin
						state_reg  <= acs_pkg::ST_CONV;
						period_reg <= 4'h0;
						sar_code   <= acs_pkg::SAR_FIRST;
					end
				end
				acs_pkg::ST_CONV: begin
					if (abort) begin
						state_reg <= acs_pkg::ST_HOLDOFF; // [RL14]
						hold_reg  <= 2'h0;
					end else if (finish) begin
						state_reg  <= acs_pkg::ST_IDLE; // [RL13]
						result_reg <= decided; // [RL1] [RL13]
					end else if (tick) begin
						period_reg <= period_reg + 4'h1;
						sar_code   <= decided;
						if (bit_idx != 4'h0 && period_reg != 4'h0) begin
							sar_code[bit_idx - 4'h1] <= 1'b1;
						end
					end
				end
				acs_pkg::ST_HOLDOFF: begin
					if (tick) begin
						hold_reg <= hold_reg + 2'h1;
						if (hold_reg == acs_pkg::ABORT_TICKS - 2'h1) begin
							state_reg <= acs_pkg::ST_IDLE; // [RL15]
						end
					end
				end
			endcase
		end
	end

	// ************************************************
	// done flag: hardware set beats software clear
	// ************************************************
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_reg <= 1'b0;
		end else if (finish) begin
			flag_reg <= 1'b1; // [RL7] [RL13]
		end else if (wr_lane0 && hit(awaddr_reg, acs_pkg::OFF_FLAGS)) begin
			flag_reg <= wdata_reg[acs_pkg::BIT_DONE]; // [RL8]
		end
	end

	// ************************************************
	// analog side and interrupt outputs
	// ************************************************
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mux_channel  <= acs_pkg::CHAN_RESET;
			conv_enable  <= 1'b0;
			ref_select   <= 1'b0;
			sample_track <= 1'b0;
			conv_irq     <= 1'b0;
			core_irq     <= 1'b0;
			wake_req     <= 1'b0;
		end else begin
			if (chan_reg == 5'h00 || (chan_reg >= 5'h02 && chan_reg <= 5'h07)
				|| (chan_reg >= 5'h0a && chan_reg <= 5'h10) || chan_reg == 5'h01
				|| (chan_reg >= 5'h18 && (chan_reg <= 5'h1c || LARGE_VARIANT))) begin
				mux_channel <= chan_reg; // [RL20]
			end
			conv_enable  <= on_reg;
			ref_select   <= refsel_reg; // [RL23]
			sample_track <= on_reg && state_reg == acs_pkg::ST_IDLE; // [RL15]
			conv_irq     <= flag_reg && irq_en_reg; // [RL9]
			core_irq     <= flag_reg && irq_en_reg && peri_en_reg && glob_en_reg; // [RL9] [RL10]
			wake_req     <= sleep_s && flag_reg && irq_en_reg; // [RL10]
		end
	end

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	logic [3:0] seen_reg;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			seen_reg <= 4'h0;
		end else if (start_ok) begin
			seen_reg <= 4'h0;
		end else if (state_reg == acs_pkg::ST_CONV && tick) begin
			seen_reg <= seen_reg + 4'h1;
		end
	end

	sequence s_finish; finish; endsequence
	sequence s_abort; abort && !(wr_ctla && !wdata_reg[acs_pkg::BIT_ON]); endsequence

	AST_ELEVEN: assert property (s_finish |-> seen_reg == 4'ha) // [RL5]
		else $error("conversion length wrong");
	AST_COMPLETE: assert property (s_finish |=> flag_reg // [RL13]
		&& result_reg == $past(decided) && state_reg == acs_pkg::ST_IDLE)
		else $error("completion incomplete");
	AST_ABORT_KEEP: assert property (s_abort |=> $stable(result_reg)[*2]) // [RL14]
		else $error("result changed after abort");
	AST_HOLDOFF: assert property (s_abort |=> state_reg == acs_pkg::ST_HOLDOFF && !tick) // [RL15]
		else $error("holdoff not entered");
	AST_FLAG_KEEP: assert property (flag_reg && !(wr_lane0 && hit(awaddr_reg, // [RL8]
		acs_pkg::OFF_FLAGS)) |=> flag_reg) else $error("flag cleared by hardware");
	AST_OFF_IGNORE: assert property (wr_ctla && !on_reg // [RL24]
		&& state_reg == acs_pkg::ST_IDLE
		|=> state_reg == acs_pkg::ST_IDLE && $stable(flag_reg))
		else $error("start accepted while off");
	AST_BUSY_IGNORE: assert property (state_reg == acs_pkg::ST_CONV && wr_ctla // [RL25]
		&& wdata_reg[acs_pkg::BIT_GO] && wdata_reg[acs_pkg::BIT_ON]
		|=> state_reg != acs_pkg::ST_HOLDOFF && $stable(sar_code) || $past(tick))
		else $error("restart disturbed conversion");
	AST_IRQ: assert property (flag_reg && irq_en_reg |=> conv_irq) // [RL9]
		else $error("irq request missing");
	AST_WAKE: assert property (sleep_s && flag_reg && irq_en_reg |=> wake_req) // [RL10]
		else $error("no wake on irq");
	AST_SLEEP: assert property (sleep_s && $past(sleep_s) && !wr_ctla // [RL17]
		&& state_reg == acs_pkg::ST_CONV |=> $stable(period_reg))
		else $error("conversion ran asleep");
endmodule // acs_sequencer
`default_nettype wire

/* logic/acs_tick_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module acs_tick_gen #(
	parameter logic [6:0] RC_DIV = 7'h10
) (
	input  wire logic       ref_clk, // system clock
	input  wire logic       arst_n,  // async reset
	input  wire logic       run,     // count while high
	input  wire logic [2:0] clk_sel, // conv_clock_select
	output logic            tick     // one bit period elapsed
);
	logic [6:0] div;
	logic [6:0] cnt_reg;

	// divisor per select code, reserved codes give none
	always_comb begin
		unique case (clk_sel)
			3'h1:        div = acs_pkg::DIV_8;
			3'h5:        div = acs_pkg::DIV_16;
			3'h2:        div = acs_pkg::DIV_32;
			3'h6:        div = acs_pkg::DIV_64;
			3'h3, 3'h7:  div = RC_DIV; // [RL4]
			default:     div = 7'h00;
		endcase
	end

	// period counter and enable pulse
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 7'h00;
			tick    <= 1'b0;
		end else if (!run || div == 7'h00) begin
			cnt_reg <= 7'h00;
			tick    <= 1'b0;
		end else if (cnt_reg == div - 7'h01) begin
			cnt_reg <= 7'h00;
			tick    <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 7'h01;
			tick    <= 1'b0;
		end
	end
endmodule // acs_tick_gen
`default_nettype wire

/* sim/acs_conv_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ************************************************
// converter core: hold node and comparator
// ************************************************
module acs_conv_model (
	input  wire logic       ref_clk,      // system clock
	input  wire logic       conv_enable,  // converter powered
	input  wire logic       sample_track, // hold node tracking
	input  wire logic [9:0] sar_code,     // trial code
	input  wire logic [9:0] vin_code,     // analog input as a code
	output logic            cmp_in        // held input at or above trial
);
	logic [9:0] held;
	logic       noise = 1'b0;
	// hold node follows the input only while tracking
	always_ff @(posedge ref_clk) begin
		if (sample_track)
			held <= vin_code;
		noise <= ~noise;
	end
	// unpowered comparator output is meaningless, so it wanders
	assign cmp_in = conv_enable ? (held >= sar_code) : noise;
endmodule // acs_conv_model
`default_nettype wire

/* sim/adc_conversion_sequencer_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_sequencer_tb;
	logic        ref_clk = 1'b0;
	logic        arst_n  = 1'b0;
	logic        sleep   = 1'b0;
	logic [7:0]  awaddr  = 8'h00;
	logic [7:0]  araddr  = 8'h00;
	logic [31:0] wdata   = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic [9:0]  vin     = 10'h000;
	logic [31:0] rdata;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, cmp_in;
	logic [4:0]  mux_ch;
	logic        conv_en, ref_sel, track, conv_irq, core_irq, wake_req;
	logic [9:0]  sar_code;
	int          failures    = 0;
	int          checks_done = 0;

	// clock at 100 MHz
	always #5 ref_clk = ~ref_clk;

	acs_sequencer DUT (.ref_clk(ref_clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sleep_mode(sleep), .cmp_in(cmp_in), .mux_channel(mux_ch),
		.conv_enable(conv_en), .ref_select(ref_sel), .sample_track(track),
		.sar_code(sar_code), .conv_irq(conv_irq), .core_irq(core_irq), .wake_req(wake_req));

	acs_conv_model core (.ref_clk(ref_clk), .conv_enable(conv_en), .sample_track(track),
		.sar_code(sar_code), .vin_code(vin), .cmp_in(cmp_in));

	// ************************************************
	// verdict, compare and bus tasks
	// ************************************************
	task automatic print_verdict;
		if (failures == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic hang;
		failures++;
		$display("mismatch at %0t: wait ran out", $time);
		print_verdict;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge ref_clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready)
				break;
		end
		if (n == 40)
			hang;
		bready <= 1'b0;
		cmp({30'h0, bresp}, {30'h0, er}, "write resp");
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge ref_clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready)
				break;
		end
		if (n == 40)
			hang;
		rready <= 1'b0;
		cmp(rdata, exp, "read data");
		cmp({30'h0, rresp}, {30'h0, er}, "read resp");
		@(posedge ref_clk);
	endtask

	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		int n;
		int i;
		longint t0;
		longint cyc;
		logic [9:0] v;
		static logic [2:0] codes [6] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
		static int divs [6] = '{8, 16, 32, 64, 16, 16};
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		for (i = 0; i < 8; i++)
			rd(8'(i * 4), 32'h0, (i == 7) ? acs_pkg::RESP_SLVERR : acs_pkg::RESP_OKAY);
		wr(acs_pkg::OFF_ENABLES, 32'h1, 2'h0);
		wr(acs_pkg::OFF_IRQ_CTRL, 32'hc0, 2'h0);
		wr(acs_pkg::OFF_CTRL_A, 32'h61, 2'h0);
		cmp({27'h0, mux_ch}, 32'h18, "mux channel");
		cmp({31'h0, conv_en}, 32'h1, "converter on");
		// one conversion per clock code, osc/8 is safe at this clock
		for (i = 0; i < 6; i++) begin
			v = 10'h3a5 - 10'(i * 157);
			vin <= v;
			if (i == 5)
				wr(acs_pkg::OFF_IRQ_CTRL, 32'h40, 2'h0);
			wr(acs_pkg::OFF_CTRL_B, {25'h0, codes[i], 4'h0}, 2'h0);
			repeat (20) @(posedge ref_clk);
			wr(acs_pkg::OFF_CTRL_A, 32'h63, 2'h0);
			t0 = $time;
			if (i == 3) begin
				wr(acs_pkg::OFF_CTRL_A, 32'h63, 2'h0);
				rd(acs_pkg::OFF_CTRL_A, 32'h63, 2'h0);
			end
			for (n = 0; n < 800 && conv_irq !== 1'b1; n++)
				@(posedge ref_clk);
			if (n == 800)
				hang;
			cyc = ($time - t0) / 10;
			cmp({31'h0, cyc >= 11 * divs[i] - 2 && cyc <= 11 * divs[i] + 2}, 32'h1, "length");
			cmp({31'h0, core_irq}, {31'h0, i < 5}, "core irq");
			rd(acs_pkg::OFF_CTRL_A, 32'h61, 2'h0);
			rd(acs_pkg::OFF_FLAGS, 32'h1, 2'h0);
			rd(acs_pkg::OFF_RES_HIGH, {30'h0, v[9:8]}, 2'h0);
			rd(acs_pkg::OFF_RES_LOW, {24'h0, v[7:0]}, 2'h0);
			if (i == 5) begin
				sleep <= 1'b1;
				repeat (6) @(posedge ref_clk);
				cmp({31'h0, wake_req}, 32'h1, "wake");
				sleep <= 1'b0;
			end
			wr(acs_pkg::OFF_FLAGS, 32'h0, 2'h0);
			cmp({31'h0, conv_irq}, 32'h0, "irq after clear");
		end
		// abort a slow conversion, result must stay
		vin <= 10'h0f0;
		wr(acs_pkg::OFF_CTRL_B, 32'h60, 2'h0);
		wr(acs_pkg::OFF_CTRL_A, 32'h63, 2'h0);
		repeat (200) @(posedge ref_clk);
		wr(acs_pkg::OFF_CTRL_A, 32'h61, 2'h0);
		cmp({31'h0, track}, 32'h0, "holdoff");
		for (n = 0; n < 200 && track !== 1'b1; n++)
			@(posedge ref_clk);
		cmp({31'h0, n >= 127 && n <= 131}, 32'h1, "holdoff length");
		repeat (800) @(posedge ref_clk);
		rd(acs_pkg::OFF_FLAGS, 32'h0, 2'h0);
		rd(acs_pkg::OFF_RES_LOW, {24'h0, v[7:0]}, 2'h0);
		// sleep freezes a running conversion, waking lets it finish
		wr(acs_pkg::OFF_CTRL_B, 32'h10, 2'h0);
		wr(acs_pkg::OFF_CTRL_A, 32'h63, 2'h0);
		sleep <= 1'b1;
		repeat (300) @(posedge ref_clk);
		rd(acs_pkg::OFF_CTRL_A, 32'h63, 2'h0);
		rd(acs_pkg::OFF_FLAGS, 32'h0, 2'h0);
		sleep <= 1'b0;
		repeat (300) @(posedge ref_clk);
		rd(acs_pkg::OFF_CTRL_A, 32'h61, 2'h0);
		rd(acs_pkg::OFF_RES_LOW, 32'hf0, 2'h0);
		wr(acs_pkg::OFF_FLAGS, 32'h0, 2'h0);
		// reserved channel kept off the mux, extra pin reaches it
		wr(acs_pkg::OFF_CTRL_A, 32'h21, 2'h0);
		cmp({27'h0, mux_ch}, 32'h18, "reserved channel");
		rd(acs_pkg::OFF_CTRL_A, 32'h21, 2'h0);
		wr(acs_pkg::OFF_CTRL_A, 32'h7d, 2'h0);
		cmp({27'h0, mux_ch}, 32'h1f, "pin channel");
		wr(acs_pkg::OFF_CTRL_B, 32'h11, 2'h0);
		cmp({31'h0, ref_sel}, 32'h1, "reference");
		// start with converter off is ignored
		wr(acs_pkg::OFF_CTRL_A, 32'h60, 2'h0);
		cmp({31'h0, conv_en}, 32'h0, "converter off");
		wr(acs_pkg::OFF_CTRL_A, 32'h62, 2'h0);
		repeat (100) @(posedge ref_clk);
		rd(acs_pkg::OFF_CTRL_A, 32'h60, 2'h0);
		rd(acs_pkg::OFF_FLAGS, 32'h0, 2'h0);
		// reset in mid conversion
		wr(acs_pkg::OFF_CTRL_A, 32'h61, 2'h0);
		wr(acs_pkg::OFF_CTRL_A, 32'h63, 2'h0);
		repeat (30) @(posedge ref_clk);
		arst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (100) @(posedge ref_clk);
		rd(acs_pkg::OFF_CTRL_A, 32'h0, 2'h0);
		rd(acs_pkg::OFF_FLAGS, 32'h0, 2'h0);
		rd(acs_pkg::OFF_RES_LOW, 32'h0, 2'h0);
		print_verdict;
	end
endmodule // adc_conversion_sequencer_tb
`default_nettype wire
